// >>> src/aux_rx_pkg.sv
/*
  Constants, field layouts and carrier types shared by the auxiliary receive
  position block and its word buffer.
  Assumes every user of it runs on the single link-side clock.
*/
package aux_rx_pkg;

  localparam int unsigned DATA_W = 64;
  localparam int unsigned FLAG_W = 8;
  localparam logic [63:0] NARROW_DATA_MASK = 64'h0000_0000_ffff_ffff;
  localparam logic [7:0] NARROW_FLAG_MASK = 8'h0f;

  localparam logic [7:0] HF_LAST = 8'h95;
  localparam logic [7:0] BF_LAST = 8'hff;

  localparam logic [11:0] RST_BFN = 12'h000;
  localparam logic [7:0] RST_HF = 8'h00;
  localparam logic [7:0] RST_BF = 8'h00;
  localparam logic [6:0] RST_SEQ = 7'h00;

  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned TX_BASE_LATENCY = 1;
  localparam int unsigned TX_EXTRA_MAX = 7;
  localparam int unsigned TX_PIPE_DEPTH = TX_BASE_LATENCY + TX_EXTRA_MAX;

  // Line rate codes, lowest rate first.
  localparam logic [3:0] RATE_0G6 = 4'h0;
  localparam logic [3:0] RATE_1G2 = 4'h1;
  localparam logic [3:0] RATE_2G4 = 4'h2;
  localparam logic [3:0] RATE_3G0 = 4'h3;
  localparam logic [3:0] RATE_4G9 = 4'h4;
  localparam logic [3:0] RATE_6G1 = 4'h5;
  localparam logic [3:0] RATE_8G1 = 4'h6;
  localparam logic [3:0] RATE_9G8 = 4'h7;
  localparam logic [3:0] RATE_10G1 = 4'h8;
  localparam logic [3:0] RATE_12G1 = 4'h9;
  localparam logic [3:0] RATE_24G3 = 4'ha;

  typedef struct packed {
    logic frame_start;
    logic [11:0] bfn;
    logic [7:0] ctrl;
    logic [63:0] data;
  } rx_word_t;

  typedef struct packed {
    logic rfp;
    logic hfp;
    logic [11:0] bfn;
    logic [7:0] hf;
    logic [7:0] bf;
    logic [6:0] seq;
  } rx_position_t;

  // Last word index of a basic frame for a rate and path width.
  function automatic logic [6:0] seq_last(input logic [3:0] rate, input logic wide);
    logic [6:0] n;
    n = 7'h03;
    case (rate)
      RATE_0G6: n = 7'h03;
      RATE_1G2: n = 7'h07;
      RATE_2G4: n = 7'h0f;
      RATE_3G0: n = 7'h13;
      RATE_4G9: n = 7'h1f;
      RATE_6G1: n = 7'h27;
      RATE_8G1: n = 7'h3f;
      RATE_9G8: n = 7'h3f;
      RATE_10G1: n = 7'h4f;
      RATE_12G1: n = 7'h5f;
      RATE_24G3: n = 7'h00;
      default: n = 7'h03;
    endcase
    if (rate == RATE_24G3)
    begin
      seq_last = 7'h5f;
    end
    else if (wide)
    begin
      seq_last = {1'b0, n[6:1]};
    end
    else
    begin
      seq_last = n;
    end
  endfunction

endpackage

// >>> src/aux_rx_frame_position.sv
/*
  Receive side of the auxiliary frame-access port: a word buffer and the
  position tracker that tags each delivered word with its place in the
  radio frame, plus the delayed transmit write path.
  Assumes the far-end logic samples and drives every port on sys_clk_i.
*/
`timescale 1ns/1ps

module aux_word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic [WIDTH-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign wr_ready_o = (st_r.count != CW'(DEPTH));
  assign rd_valid_o = (st_r.count != '0);
  assign rd_data_o = st_r.mem[st_r.rd_ptr];
  assign push = wr_valid_i && wr_ready_o;
  assign pop = rd_valid_o && rd_ready_i;

  // Pointers wrap at the depth; count tracks pushes minus pops.
  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wr_ptr] = wr_data_i;
      st_nxt.wr_ptr = (st_r.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_r.wr_ptr + AW'(1);
    end
    if (pop)
    begin
      st_nxt.rd_ptr = (st_r.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_r.rd_ptr + AW'(1);
    end
    if (push && !pop)
    begin
      st_nxt.count = st_r.count + CW'(1);
    end
    else if (pop && !push)
    begin
      st_nxt.count = st_r.count - CW'(1);
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // The count never passes the depth, so a push while full is caught.
  fifo_no_overflow_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    st_r.count <= CW'(DEPTH))
    else $error("Word buffer holds more words than its depth.");

  // A pushed word is offered on the read side from the next cycle.
  fifo_push_shows_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    push |=> rd_valid_o)
    else $error("Pushed word not offered on the read side.");
endmodule // aux_word_fifo

module aux_rx_frame_position #(
  parameter int unsigned EXTRA_LATENCY = 0
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic aux_enable_i,
  input wire logic path_64_i,
  input wire logic [3:0] line_rate_i,
  input wire logic rate_negotiated_down_i,
  input wire aux_rx_pkg::rx_word_t in_word_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [63:0] rx_word_bus_o,
  output logic [7:0] rx_control_byte_flags_o,
  output logic rx_radio_frame_pulse_o,
  output logic rx_hyperframe_pulse_o,
  output logic [11:0] rx_radio_frame_number_o,
  output logic [7:0] rx_hyperframe_number_o,
  output logic [7:0] rx_basic_frame_index_o,
  output logic [6:0] rx_word_index_o,
  output logic wide_format_o,
  output logic aux_has_priority_o,
  input wire logic [63:0] tx_word_i,
  input wire logic tx_valid_i,
  output logic [63:0] tx_word_o,
  output logic tx_valid_o
);
  typedef struct packed {
    logic owns;
    logic started;
    logic out_valid;
    aux_rx_pkg::rx_position_t pos;
    logic [63:0] data;
    logic [7:0] flags;
    logic [aux_rx_pkg::TX_PIPE_DEPTH-1:0][64:0] tx_pipe;
  } top_state_t;

  top_state_t st_r;
  top_state_t st_nxt;
  aux_rx_pkg::rx_word_t buf_word;
  logic buf_valid;
  logic buf_ready;
  logic accept;
  logic restart;
  logic wide;
  logic [6:0] last_seq;

  // Path width: the highest rates, and rates negotiated down from them, stay wide.
  always_comb
  begin
    wide = path_64_i;
    if (line_rate_i == aux_rx_pkg::RATE_12G1 || line_rate_i == aux_rx_pkg::RATE_24G3)
    begin
      wide = 1'b1;
    end
    if (rate_negotiated_down_i && (line_rate_i == aux_rx_pkg::RATE_8G1 ||
        line_rate_i == aux_rx_pkg::RATE_10G1))
    begin
      wide = 1'b1;
    end
  end

  assign last_seq = aux_rx_pkg::seq_last(line_rate_i, wide);

  // Word buffer between the deframer and the user; user stalls reach in_ready_o.
  aux_word_fifo #(
    .WIDTH($bits(aux_rx_pkg::rx_word_t)),
    .DEPTH(aux_rx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .wr_data_i(in_word_i),
    .wr_valid_i(in_valid_i && st_r.owns),
    .wr_ready_o(buf_ready),
    .rd_data_o(buf_word),
    .rd_valid_o(buf_valid),
    .rd_ready_i(accept)
  );

  // The port only moves words while enabled; the output stage refills when free.
  assign in_ready_o = buf_ready && st_r.owns;
  assign accept = buf_valid && st_r.owns && (!st_r.out_valid || rx_ready_i);
  assign restart = buf_word.frame_start || !st_r.started;

  // Next state: position tracking, output word stage and transmit delay line.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.owns = aux_enable_i;
    if (st_r.out_valid && rx_ready_i)
    begin
      st_nxt.out_valid = 1'b0;
    end
    if (accept)
    begin
      st_nxt.out_valid = 1'b1;
      st_nxt.started = 1'b1;
      // Bytes keep their lanes, first byte in the top lane; narrow mode clears the upper half.
      st_nxt.data = wide ? buf_word.data : (buf_word.data & aux_rx_pkg::NARROW_DATA_MASK);
      st_nxt.flags = wide ? buf_word.ctrl : (buf_word.ctrl & aux_rx_pkg::NARROW_FLAG_MASK);
      st_nxt.pos.rfp = 1'b0;
      st_nxt.pos.hfp = 1'b0;
      if (restart)
      begin
        st_nxt.pos.rfp = 1'b1;
        st_nxt.pos.hfp = 1'b1;
        st_nxt.pos.bfn = buf_word.bfn;
        st_nxt.pos.hf = aux_rx_pkg::RST_HF;
        st_nxt.pos.bf = aux_rx_pkg::RST_BF;
        st_nxt.pos.seq = aux_rx_pkg::RST_SEQ;
      end
      else if (st_r.pos.seq < last_seq)
      begin
        st_nxt.pos.seq = st_r.pos.seq + 7'h01;
      end
      else
      begin
        st_nxt.pos.seq = aux_rx_pkg::RST_SEQ;
        if (st_r.pos.bf != aux_rx_pkg::BF_LAST)
        begin
          st_nxt.pos.bf = st_r.pos.bf + 8'h01;
        end
        else
        begin
          st_nxt.pos.bf = aux_rx_pkg::RST_BF;
          st_nxt.pos.hfp = 1'b1;
          if (st_r.pos.hf < aux_rx_pkg::HF_LAST)
          begin
            st_nxt.pos.hf = st_r.pos.hf + 8'h01;
          end
          else
          begin
            st_nxt.pos.hf = aux_rx_pkg::RST_HF;
            st_nxt.pos.rfp = 1'b1;
            st_nxt.pos.bfn = st_r.pos.bfn + 12'h001;
          end
        end
      end
    end
    // Transmit writes ride a delay line; the tap sets one plus extra cycles.
    st_nxt.tx_pipe[0] = {tx_valid_i, tx_word_i};
    for (int i = 1; i < aux_rx_pkg::TX_PIPE_DEPTH; i++)
    begin
      st_nxt.tx_pipe[i] = st_r.tx_pipe[i - 1];
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs come from the state register, except wide_format_o which is combinational; pulses are qualified by a valid word.
  assign rx_valid_o = st_r.out_valid;
  assign rx_word_bus_o = st_r.data;
  assign rx_control_byte_flags_o = st_r.flags;
  assign rx_radio_frame_pulse_o = st_r.pos.rfp && st_r.out_valid;
  assign rx_hyperframe_pulse_o = st_r.pos.hfp && st_r.out_valid;
  assign rx_radio_frame_number_o = st_r.pos.bfn;
  assign rx_hyperframe_number_o = st_r.pos.hf;
  assign rx_basic_frame_index_o = st_r.pos.bf;
  assign rx_word_index_o = st_r.pos.seq;
  assign wide_format_o = wide;
  assign aux_has_priority_o = st_r.owns;
  assign tx_word_o = st_r.tx_pipe[EXTRA_LATENCY][63:0];
  assign tx_valid_o = st_r.tx_pipe[EXTRA_LATENCY][64];

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  disabled_port_idle_a: assert property (
    !aux_enable_i |=> !in_ready_o && !accept)
    else $error("Auxiliary port moves words while disabled.");

  tx_write_latency_a: assert property (
    tx_valid_i |-> ##(EXTRA_LATENCY + 1) tx_valid_o)
    else $error("Transmit write latency is wrong.");

  narrow_lanes_zero_a: assert property (
    rx_valid_o && !$past(wide) && $past(accept) |-> rx_word_bus_o[63:32] == 32'h0000_0000
      && rx_control_byte_flags_o[7:4] == 4'h0)
    else $error("Narrow path shows upper lanes.");

  rfp_at_start_a: assert property (
    rx_radio_frame_pulse_o |-> rx_hyperframe_pulse_o && rx_hyperframe_number_o == 8'h00
      && rx_basic_frame_index_o == 8'h00 && rx_word_index_o == 7'h00)
    else $error("Radio-frame pulse away from frame start.");

  hfp_at_start_a: assert property (
    rx_hyperframe_pulse_o |-> rx_basic_frame_index_o == 8'h00 && rx_word_index_o == 7'h00)
    else $error("Hyperframe pulse away from hyperframe start.");

  bfn_advance_a: assert property (
    accept && !restart && st_r.pos.hf == 8'h95 && st_r.pos.bf == 8'hff
      && st_r.pos.seq == last_seq |=> rx_radio_frame_number_o == $past(st_r.pos.bfn) + 12'h001
      && rx_radio_frame_pulse_o)
    else $error("Radio frame number did not advance.");

  hf_in_range_a: assert property (
    rx_hyperframe_number_o <= 8'h95)
    else $error("Hyperframe number out of range.");

  bf_wrap_a: assert property (
    accept && !restart && st_r.pos.bf == 8'hff && st_r.pos.seq == last_seq
      |=> rx_basic_frame_index_o == 8'h00 && rx_hyperframe_pulse_o)
    else $error("Basic-frame index failed to wrap.");

  seq_in_range_a: assert property (
    accept && !restart |=> rx_word_index_o <= $past(last_seq))
    else $error("Word index beyond rate limit.");

  wide_when_fast_a: assert property (
    (line_rate_i == 4'h9 || line_rate_i == 4'ha) |-> wide_format_o)
    else $error("Highest rates not in wide format.");

  wide_when_down_a: assert property (
    rate_negotiated_down_i && (line_rate_i == 4'h6 || line_rate_i == 4'h8) |-> wide_format_o)
    else $error("Negotiated-down rate lost wide format.");

  stall_holds_word_a: assert property (
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_word_bus_o)
      && $stable(rx_word_index_o))
    else $error("Output word changed while stalled.");

  seq_step_a: assert property (
    accept && !restart && st_r.pos.seq < last_seq
      |=> rx_word_index_o == $past(st_r.pos.seq) + 7'h01)
    else $error("Word index did not step by one.");

  restart_load_a: assert property (
    accept && restart |=> rx_radio_frame_number_o == $past(buf_word.bfn)
      && rx_radio_frame_pulse_o && rx_word_index_o == 7'h00)
    else $error("Frame start did not reload the position.");

  hf_step_a: assert property (
    accept && !restart && st_r.pos.bf == aux_rx_pkg::BF_LAST && st_r.pos.seq == last_seq
      && st_r.pos.hf < aux_rx_pkg::HF_LAST
      |=> rx_hyperframe_number_o == $past(st_r.pos.hf) + 8'h01)
    else $error("Hyperframe number did not step by one.");

  tx_word_delay_a: assert property (
    tx_valid_i |-> ##(EXTRA_LATENCY + 1) tx_word_o == $past(tx_word_i, EXTRA_LATENCY + 1))
    else $error("Transmit word changed in the delay line.");
endmodule // aux_rx_frame_position

// >>> tb/aux_rx_sink.sv
/*
  Model of the user routing logic that takes words off the receive port.
  Assumes it shares the single link clock with the block.
*/
`timescale 1ns/1ps

module aux_rx_sink (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [1:0] mode_i,
  output logic rx_ready_o
);
  logic [1:0] cnt_r;

  // Mode 0 is prompt, mode 1 stalls one cycle in four and mode 2 stops taking words.
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_r <= 2'h0;
      rx_ready_o <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 2'h1;
      rx_ready_o <= #1 (mode_i == 2'h0) || (mode_i == 2'h1 && cnt_r != 2'h3);
    end
  end
endmodule // aux_rx_sink

// >>> tb/aux_rx_frame_position_tb.sv
/*
  Self-checking bench for the receive position tracker and transmit delay.
  Assumes the sink model of aux_rx_sink.sv on the receive port.
*/
`timescale 1ns/1ps

module aux_rx_frame_position_tb;
  localparam int XL = 2;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic aux_enable_i = 1'b1;
  logic path_64_i = 1'b0;
  logic [3:0] line_rate_i = 4'h0;
  logic rate_negotiated_down_i = 1'b0;
  aux_rx_pkg::rx_word_t in_word_i = '0;
  logic in_valid_i = 1'b0;
  logic [63:0] tx_word_i = '0;
  logic tx_valid_i = 1'b0;
  logic [1:0] mode = 2'h0;
  logic in_ready_o, rx_valid_o, rx_ready_i, rx_radio_frame_pulse_o, rx_hyperframe_pulse_o;
  logic [63:0] rx_word_bus_o, tx_word_o;
  logic [7:0] rx_control_byte_flags_o, rx_hyperframe_number_o, rx_basic_frame_index_o;
  logic [11:0] rx_radio_frame_number_o;
  logic [6:0] rx_word_index_o;
  logic wide_format_o, aux_has_priority_o, tx_valid_o;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int e_seq, e_bf, e_hf, e_bfn;
  aux_rx_pkg::rx_word_t q[$];

  always #20 sys_clk_i = ~sys_clk_i;

  aux_rx_frame_position #(.EXTRA_LATENCY(XL)) uut (.sys_clk_i, .arst_n_i, .aux_enable_i,
    .path_64_i, .line_rate_i, .rate_negotiated_down_i, .in_word_i, .in_valid_i, .in_ready_o,
    .rx_valid_o, .rx_ready_i, .rx_word_bus_o, .rx_control_byte_flags_o, .rx_radio_frame_pulse_o,
    .rx_hyperframe_pulse_o, .rx_radio_frame_number_o, .rx_hyperframe_number_o,
    .rx_basic_frame_index_o, .rx_word_index_o, .wide_format_o, .aux_has_priority_o, .tx_word_i,
    .tx_valid_i, .tx_word_o, .tx_valid_o);

  aux_rx_sink sink (.sys_clk_i, .arst_n_i, .mode_i(mode), .rx_ready_o(rx_ready_i));

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected wide format and last word index, from the configuration the bench drives.
  function automatic logic wexp();
    return path_64_i || line_rate_i > 4'h8 ||
      (rate_negotiated_down_i && (line_rate_i == 4'h6 || line_rate_i == 4'h8));
  endfunction

  function automatic int lim();
    int nl[11] = '{3, 7, 15, 19, 31, 39, 63, 63, 79, 95, 95};
    int wl[11] = '{1, 3, 7, 9, 15, 19, 31, 31, 39, 47, 95};
    return wexp() ? wl[line_rate_i] : nl[line_rate_i];
  endfunction

  // Each delivered word is judged against the word sent and the expected position.
  task automatic check_out;
    aux_rx_pkg::rx_word_t w;
    logic fs, ws, wb, wh;
    w = q.pop_front();
    fs = w.frame_start;
    ws = e_seq == lim();
    wb = ws && e_bf == 255;
    wh = wb && e_hf == 149;
    e_seq = (fs || ws) ? 0 : e_seq + 1;
    e_bf = (fs || wb) ? 0 : e_bf + int'(ws);
    e_hf = (fs || wh) ? 0 : e_hf + int'(wb);
    e_bfn = fs ? int'(w.bfn) : (e_bfn + int'(wh)) % 4096;
    chk(rx_word_index_o, e_seq);
    chk(rx_basic_frame_index_o, e_bf);
    chk(rx_hyperframe_number_o, e_hf);
    chk(rx_radio_frame_number_o, e_bfn);
    chk(rx_radio_frame_pulse_o, e_seq == 0 && e_bf == 0 && e_hf == 0);
    chk(rx_hyperframe_pulse_o, e_seq == 0 && e_bf == 0);
    chk(rx_word_bus_o, wexp() ? w.data : w.data & aux_rx_pkg::NARROW_DATA_MASK);
    chk(rx_control_byte_flags_o, wexp() ? w.ctrl : w.ctrl & aux_rx_pkg::NARROW_FLAG_MASK);
  endtask

  // Words taken at the input are queued; words taken at the output are checked.
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      stop_test();
    end
    if (arst_n_i && in_valid_i && in_ready_o)
      q.push_back(in_word_i);
    if (arst_n_i && rx_valid_o && rx_ready_i)
      check_out();
  end

  task automatic do_reset;
    arst_n_i = 1'b0;
    q.delete();
    repeat (16) @(posedge sys_clk_i);
    #1 arst_n_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  // Offers n words, holding each until an edge that finds the block ready.
  task automatic send(input int n, input int fs_at);
    int i, k;
    for (i = 0; i < n; i++)
    begin
      in_word_i.frame_start = (i == 0) || (i == fs_at);
      in_word_i.bfn = 12'h5a5 + i[11:0];
      in_word_i.ctrl = i[7:0];
      in_word_i.data = {i[7:0], 56'h11_2233_4455_6677};
      in_valid_i = 1'b1;
      k = 0;
      while (in_ready_o !== 1'b1 && k < 300)
      begin
        @(posedge sys_clk_i);
        #1 k++;
      end
      @(posedge sys_clk_i);
      #1;
    end
    in_valid_i = 1'b0;
  endtask

  task automatic drain;
    int k;
    k = 0;
    while (q.size() != 0 && k < 600)
    begin
      @(posedge sys_clk_i);
      #1 k++;
    end
    chk(q.size(), 0);
  endtask

  task automatic t_stream(input int r, input logic p, input logic ng, input int n);
    line_rate_i = r[3:0];
    path_64_i = p;
    rate_negotiated_down_i = ng;
    mode = {1'b0, r[0]};
    do_reset;
    send(n == 0 ? 2 * lim() + 5 : n, lim() + 3);
    drain;
    $display("Stream at rate %0d wide %0d done", r, wexp());
  endtask

  // Stalled sink: the buffer and output stage fill, further offers are refused.
  task automatic t_fill;
    mode = 2'h2;
    do_reset;
    send(17, 99);
    chk(in_ready_o, 0);
    @(posedge sys_clk_i);
    #1 in_valid_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 in_valid_i = 1'b0;
    chk(in_ready_o, 0);
    chk(q.size(), 17);
    mode = 2'h0;
    drain;
    $display("Fill and drain done");
  endtask

  task automatic t_tx;
    int j;
    tx_word_i = 64'h0123_4567_89ab_cdef;
    tx_valid_i = 1'b1;
    for (j = 0; j < 6; j++)
    begin
      @(posedge sys_clk_i);
      #1 tx_valid_i = 1'b0;
      chk(tx_valid_o, j == XL);
      if (j == XL)
        chk(tx_word_o, 64'h0123_4567_89ab_cdef);
    end
    $display("Transmit delay done");
  endtask

  initial
  begin
    int r;
    do_reset;
    chk(aux_has_priority_o, 1);
    chk(in_ready_o, 1);
    chk(rx_valid_o, 0);
    for (r = 0; r < 11; r++)
    begin
      line_rate_i = r[3:0];
      rate_negotiated_down_i = r[0];
      @(posedge sys_clk_i);
      #1 chk(wide_format_o, wexp());
      rate_negotiated_down_i = !r[0];
      @(posedge sys_clk_i);
      #1 chk(wide_format_o, wexp());
    end
    $display("Format selection done");
    for (r = 0; r < 9; r++)
      t_stream(r, 1'b0, 1'b0, 0);
    for (r = 0; r < 11; r++)
      t_stream(r, 1'b1, 1'b0, 0);
    t_stream(6, 1'b0, 1'b1, 0);
    t_stream(10, 1'b0, 1'b0, 0);
    t_stream(0, 1'b1, 1'b0, 1100);
    t_fill;
    t_tx;
    aux_enable_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 chk(aux_has_priority_o, 0);
    chk(in_ready_o, 0);
    $display("Port disable done");
    stop_test();
  end
endmodule // aux_rx_frame_position_tb
